// *** verilog/tpgc_pkg.sv ***
// Constants and state types of the three-phase gate control core
package tpgc_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int DT_MIN_NS     = 300;
   localparam int DT_MAX_NS     = 1800;
   localparam int FLT_CLR_NS    = 15000;

   localparam int DT_W  = 7;
   localparam int CLR_W = 10;

   localparam logic [DT_W-1:0]  DT_MIN_CYC  =
      DT_W'((DT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [DT_W-1:0]  DT_MAX_CYC  = DT_W'(DT_MAX_NS / CLK_PERIOD_NS);
   localparam logic [DT_W-1:0]  DT_CNT_START = DT_W'(1);
   localparam logic [CLR_W-1:0] FLT_CLR_CYC =
      CLR_W'((FLT_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   localparam int NUM_PHASES = 3;

   // ---------------------------------------------------------------
   // State of the core
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [NUM_PHASES-1:0] cmd_s1;
      logic [NUM_PHASES-1:0] cmd_s2;
      logic                  kill_n_s1;
      logic                  kill_n_s2;
      logic                  shunt_s1;
      logic                  shunt_s2;
      logic                  uv_s1;
      logic                  uv_s2;
      logic                  trip;
      logic                  trip_n;
      logic                  gate_en;
      logic [DT_W-1:0]       dead;
      logic [CLR_W-1:0]      clr_cnt;
   } tpgc_core_s;

   localparam tpgc_core_s CORE_RST = '{
      cmd_s1: '0, cmd_s2: '0, kill_n_s1: 1'b0, kill_n_s2: 1'b0,
      shunt_s1: 1'b0, shunt_s2: 1'b0, uv_s1: 1'b0, uv_s2: 1'b0,
      trip: 1'b0, trip_n: 1'b1, gate_en: 1'b0, dead: DT_MIN_CYC,
      clr_cnt: '0};

   // ---------------------------------------------------------------
   // State of one bridge leg
   // ---------------------------------------------------------------
   typedef struct packed {
      logic            cmd;
      logic [DT_W-1:0] cnt;
      logic            top;
      logic            bot;
   } tpgc_leg_s;

   localparam tpgc_leg_s LEG_RST = '{cmd: 1'b0, cnt: '0, top: 1'b0, bot: 1'b0};

endpackage

// *** verilog/tpgc_leg.sv ***
// One bridge leg: complementary top and bottom drives with dead time
`timescale 1ns/1ns
`default_nettype none
module tpgc_leg
   import tpgc_pkg::*;
(
   input  wire logic            sys_clk_i,
   input  wire logic            rst_n_i,
   input  wire logic            clk_en_i,
   input  wire logic            cmd_i,
   input  wire logic            gate_en_i,
   input  wire logic [DT_W-1:0] dead_i,
   output logic                 top_o,
   output logic                 bot_o
);

   tpgc_leg_s q;
   tpgc_leg_s d;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      if (!gate_en_i) begin
         d.cmd = cmd_i;
         d.cnt = DT_CNT_START;
         d.top = 1'b0;
         d.bot = 1'b0;
      end else if (cmd_i != q.cmd) begin
         d.cmd = cmd_i;
         d.cnt = DT_CNT_START;
         d.top = 1'b0;
         d.bot = 1'b0;
      // per-leg dead counter, idle once driving
      end else if (!(q.top || q.bot) && (q.cnt < dead_i)) begin
         d.cnt = q.cnt + DT_CNT_START;
         d.top = 1'b0;
         d.bot = 1'b0;
      end else begin
         d.top = q.cmd;
         d.bot = !q.cmd;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= LEG_RST;
      end else if (clk_en_i) begin
         q <= d;
      end
   end

   assign top_o = q.top;
   assign bot_o = q.bot;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_no_shoot_through: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      !(q.top && q.bot))
      else $error("top and bottom drives on together");

   a_top_follows_cmd: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (q.top |-> q.cmd) and (q.bot |-> !q.cmd))
      else $error("drive disagrees with phase command");

   a_dead_gap_bot: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      $fell(q.top) |-> !q.bot [*8])
      else $error("bottom drive on too soon after top off");

   a_dead_gap_top: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      $fell(q.bot) |-> !q.top [*8])
      else $error("top drive on too soon after bottom off");

   a_steady_drive_holds: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      ((q.top || q.bot) && gate_en_i && (cmd_i == q.cmd)) |=> (q.top || q.bot))
      else $error("drive dropped with steady command");

endmodule
`default_nettype wire

// *** verilog/tpgc_core.sv ***
// Three-phase gate control core: dead time, all-off, trip and undervoltage
//
// Functional notes
// - Low command: bottom on; high: top on
// - Dead time inserted on every command edge
// - Top and bottom never on together
// - All-off input low forces every drive off
// - All-off high, no trip, no undervoltage: follow commands
// - Shunt over threshold latches trip, trip low
// - Trip cleared only by all-off low
// - Trip output rises after fault clear delay
// - All-off high after clear resumes switching
// - Undervoltage forces all drives off
// - Undervoltage release is automatic
`timescale 1ns/1ns
`default_nettype none
module tpgc_core
   import tpgc_pkg::*;
(
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  clk_en_i,
   input  wire logic                  phase_u_cmd_i,
   input  wire logic                  phase_v_cmd_i,
   input  wire logic                  phase_w_cmd_i,
   input  wire logic                  gate_kill_n_i,
   input  wire logic                  shunt_sense_i,
   input  wire logic                  undervoltage_trip_i,
   input  wire logic [DT_W-1:0]       dead_cfg_i,
   output logic [NUM_PHASES-1:0]      gate_top_o,
   output logic [NUM_PHASES-1:0]      gate_bot_o,
   output logic                       trip_n_o,
   output logic                       uv_shutdown_o,
   output logic                       gates_enabled_o
);

   tpgc_core_s q;
   tpgc_core_s d;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;

      // Two-stage synchronisers for pin inputs
      d.cmd_s1    = {phase_w_cmd_i, phase_v_cmd_i, phase_u_cmd_i};
      d.cmd_s2    = q.cmd_s1;
      d.kill_n_s1 = gate_kill_n_i;
      d.kill_n_s2 = q.kill_n_s1;
      d.shunt_s1  = shunt_sense_i;
      d.shunt_s2  = q.shunt_s1;
      d.uv_s1     = undervoltage_trip_i;
      d.uv_s2     = q.uv_s1;

      if (dead_cfg_i < DT_MIN_CYC) begin
         d.dead = DT_MIN_CYC;
      end else if (dead_cfg_i > DT_MAX_CYC) begin
         d.dead = DT_MAX_CYC;
      end else begin
         d.dead = dead_cfg_i;
      end

      if (q.kill_n_s2) begin
         d.clr_cnt = '0;
      end else if (q.clr_cnt != FLT_CLR_CYC) begin
         d.clr_cnt = q.clr_cnt + CLR_W'(1);
      end

      if (q.shunt_s2) begin
         d.trip = 1'b1;
      end else if (!q.kill_n_s2 && (q.clr_cnt == FLT_CLR_CYC)) begin
         d.trip = 1'b0;
      end

      d.trip_n = !d.trip;

      d.gate_en = q.kill_n_s2 && !d.trip && !q.uv_s2;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= CORE_RST;
      end else if (clk_en_i) begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Bridge legs
   // ---------------------------------------------------------------
   for (genvar i = 0; i < NUM_PHASES; i++) begin : g_leg
      tpgc_leg u_leg (
         .sys_clk_i (sys_clk_i),
         .rst_n_i   (rst_n_i),
         .clk_en_i  (clk_en_i),
         .cmd_i     (q.cmd_s2[i]),
         .gate_en_i (q.gate_en),
         .dead_i    (q.dead),
         .top_o     (gate_top_o[i]),
         .bot_o     (gate_bot_o[i])
      );
   end

   assign trip_n_o        = q.trip_n;
   assign uv_shutdown_o   = q.uv_s2;
   assign gates_enabled_o = q.gate_en;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_kill_all_off: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      !q.kill_n_s2 |-> ##[1:2] (gate_top_o == '0 && gate_bot_o == '0))
      else $error("drives not off while all-off low");

   a_trip_latches: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      q.shunt_s2 |=> (q.trip && !trip_n_o) ##1 (gate_top_o == '0 && gate_bot_o == '0))
      else $error("over-current did not trip");

   a_trip_holds: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (q.trip && q.kill_n_s2) |=> q.trip)
      else $error("trip cleared without all-off");

   a_clear_delay: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      $rose(trip_n_o) |-> ($past(q.clr_cnt) == FLT_CLR_CYC) && !$past(q.kill_n_s2))
      else $error("trip cleared before fault clear delay");

   a_uv_all_off: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      q.uv_s2 |-> ##[1:2] (gate_top_o == '0 && gate_bot_o == '0))
      else $error("drives not off under undervoltage");

   a_uv_release: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      ($fell(q.uv_s2) && q.kill_n_s2 && !q.trip && !q.shunt_s2) |=> q.gate_en)
      else $error("undervoltage did not release");

   a_uv_keeps_flag: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (q.uv_s2 && trip_n_o && !q.shunt_s2) |=> trip_n_o)
      else $error("trip output low from undervoltage");

   a_resume_follow: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      q.gate_en |-> ($past(q.kill_n_s2) && !$past(q.uv_s2) && !q.trip))
      else $error("drives enabled without cause");

   a_kill_gates_off: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      !q.kill_n_s2 |=> !q.gate_en)
      else $error("gates enabled while all-off low");

   a_kill_time_bound: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      $fell(q.kill_n_s2) |-> ##2 (gate_top_o == '0 && gate_bot_o == '0))
      else $error("drives late to switch off after all-off");

   a_off_when_disabled: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      !q.gate_en |=> (gate_top_o == '0 && gate_bot_o == '0))
      else $error("drive on while gates disabled");

   a_resume_enable: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (q.kill_n_s2 && !q.trip && !q.uv_s2 && !q.shunt_s2) |=> q.gate_en)
      else $error("gates not enabled after all-off release");

   a_trip_clear_only: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      $fell(q.trip) |-> !$past(q.kill_n_s2))
      else $error("trip cleared while all-off high");

   a_clear_releases: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (!q.kill_n_s2 && (q.clr_cnt == FLT_CLR_CYC) && !q.shunt_s2) |=> trip_n_o)
      else $error("trip output not released after clear delay");

   a_clr_restart: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      q.kill_n_s2 |=> (q.clr_cnt == '0))
      else $error("clear timer not restarted");

   a_uv_gates_off: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      q.uv_s2 |=> !q.gate_en)
      else $error("gates enabled under undervoltage");

   a_uv_time_bound: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      $rose(q.uv_s2) |-> ##2 (gate_top_o == '0 && gate_bot_o == '0))
      else $error("drives late to switch off under undervoltage");

   a_dead_clamp_low: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (dead_cfg_i < DT_MIN_CYC) |=> (q.dead == DT_MIN_CYC))
      else $error("dead time below range");

   a_dead_clamp_high: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      (dead_cfg_i > DT_MAX_CYC) |=> (q.dead == DT_MAX_CYC))
      else $error("dead time above range");

   a_dead_cfg_taken: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i || !clk_en_i)
      ((dead_cfg_i >= DT_MIN_CYC) && (dead_cfg_i <= DT_MAX_CYC))
         |=> (q.dead == $past(dead_cfg_i)))
      else $error("dead time setting not taken");

endmodule
`default_nettype wire

// *** dv/tpgc_ctrl_model.sv ***
// Behavioural motor controller driving the gate control core
`timescale 1ns/1ns
`default_nettype none
module tpgc_ctrl_model (
   input  wire logic       sys_clk_i,
   input  wire logic       run_i,
   input  wire logic       clr_i,
   input  wire logic [2:0] cmd_i,
   output logic      [2:0] cmd_o,
   output logic            kill_n_o,
   output logic            pump_clk_o,
   output logic            busy_o
);
   int hold = 0;
   int div  = 0;
   initial kill_n_o = 1'b0;
   initial pump_clk_o = 1'b0;
   assign cmd_o  = cmd_i;
   assign busy_o = (hold != 0);
   always @(negedge sys_clk_i) begin
      if (!run_i) begin
         kill_n_o   <= 1'b0;
         pump_clk_o <= 1'b0;
         div        <= 0;
      end else begin
         div <= (div == 1499) ? 0 : div + 1;
         if (div == 1499) pump_clk_o <= ~pump_clk_o;
         if (clr_i && hold == 0) begin
            hold     <= 1500;
            kill_n_o <= 1'b0;
         end else if (hold > 1) begin
            hold <= hold - 1;
         end else if (hold == 1) begin
            hold     <= 0;
            kill_n_o <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench of the gate control core
`timescale 1ns/1ns
`default_nettype none
module tb;
   import tpgc_pkg::*;
   typedef struct packed {logic [2:0] c; logic [6:0] d; logic [7:0] dc;} tpgc_row_s;
   logic sys_clk = 1'b0, rst_n = 1'b0, run = 1'b0, clr = 1'b0, shunt = 1'b0, uv = 1'b0;
   logic [2:0] cmd = 3'h0, mcmd, top, bot;
   logic [6:0] dead_cfg = 7'h0F;
   logic kill_n, busy, trip_n, uvs, gen, pump, clk_en = 1'b1;
   int n_errors = 0, n_tests = 0, n;
   tpgc_row_s rows [4] = '{'{3'h5, 7'h0F, 8'h12}, '{3'h2, 7'h05, 8'h12},
                           '{3'h7, 7'h7F, 8'h5D}, '{3'h0, 7'h1E, 8'h21}};
   // ---------------------------------------------------------------
   // Clock, partner and design
   // ---------------------------------------------------------------
   initial forever #10 sys_clk = ~sys_clk;
   tpgc_ctrl_model u_ctrl (.sys_clk_i(sys_clk), .run_i(run), .clr_i(clr), .cmd_i(cmd),
      .cmd_o(mcmd), .kill_n_o(kill_n), .pump_clk_o(pump), .busy_o(busy));
   tpgc_core u_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .clk_en_i(clk_en),
      .phase_u_cmd_i(mcmd[0]), .phase_v_cmd_i(mcmd[1]), .phase_w_cmd_i(mcmd[2]),
      .gate_kill_n_i(kill_n), .shunt_sense_i(shunt), .undervoltage_trip_i(uv),
      .dead_cfg_i(dead_cfg), .gate_top_o(top), .gate_bot_o(bot), .trip_n_o(trip_n),
      .uv_shutdown_o(uvs), .gates_enabled_o(gen));
   // ---------------------------------------------------------------
   // Checking and closing
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge sys_clk);
   endtask
   task automatic clear_trip(input bit tripped);
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      n = 0;
      while (!(trip_n === 1'b1 && n > 2) && n < 1600) begin cyc(1); n++; end
      if (tripped) chk(8'(n >= 750 && n <= 1500), 8'h01);
      else chk(8'(n), 8'h03);
      while (busy !== 1'b0 && n < 1600) begin cyc(1); n++; end
      if (n >= 1600) begin n_errors++; finish_test(); end
   endtask
   always @(negedge sys_clk) if (rst_n) chk({5'h0, top & bot}, 8'h00);
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      cyc(6);
      chk({6'h0, kill_n, pump}, 8'h00);
      rst_n <= 1'b1;
      run <= 1'b1;
      cyc(5);
      chk({top, bot, gen}, 8'h00);
      clear_trip(1'b0);
      cyc(30);
      foreach (rows[i]) begin
         dead_cfg <= rows[i].d;
         cyc(1);
         cmd <= rows[i].c;
         n = 0;
         while ({top, bot} !== {rows[i].c, ~rows[i].c} && n < 200) begin cyc(1); n++; end
         chk(8'(n), rows[i].dc);
         chk({top, bot}, {2'h0, rows[i].c, ~rows[i].c});
      end
      cmd <= 3'h1;
      cyc(5);
      cmd <= 3'h0;
      cyc(60);
      chk({top, bot}, 8'h07);
      shunt <= 1'b1;
      cyc(4);
      chk({trip_n, top, bot}, 8'h00);
      shunt <= 1'b0;
      cyc(20);
      chk({trip_n, top, bot}, 8'h00);
      clear_trip(1'b1);
      cyc(40);
      chk({trip_n, top, bot}, 8'h47);
      uv <= 1'b1;
      cyc(4);
      chk({uvs, trip_n, top, bot}, 8'hC0);
      uv <= 1'b0;
      cyc(40);
      chk({uvs, trip_n, top, bot}, 8'h47);
      clk_en <= 1'b0;
      cmd <= 3'h7;
      cyc(50);
      chk({gen, top, bot}, 8'h47);
      clk_en <= 1'b1;
      cyc(40);
      chk({top, bot}, 8'h38);
      finish_test();
   end
   initial begin
      #1000000;
      n_errors++;
      finish_test();
   end
endmodule
`default_nettype wire
